// ===== stme_consts.svh
`ifndef STME_CONSTS_SVH
`define STME_CONSTS_SVH

// Strap status byte layout (bridge function config offset)
`define STME_STATUS_OFFSET      8'hD4
`define STME_NO_REBOOT_BIT      1
`define STME_SAFE_MODE_BIT      2

// Strap setup and test-mode decode counts, in PCI clocks
`define STME_SETUP_CLOCKS       4
`define STME_TEST_MIN           5'h04
`define STME_TEST_ALLZ          5'h08
`define STME_TEST_NONE9         5'h09
`define STME_TEST_RSVD_MAX      5'h18
`define STME_COUNT_MAX          5'h1F

// Reset values: speaker strap pulled up, codec strap pulled down
`define STME_SPEAKER_STRAP_PIN_RESET         1'h1
`define STME_CODEC_RESET        1'h0

`endif

// ===== stme_pkg.sv
`default_nettype none

package stme_pkg;

    typedef enum logic [2:0] {
        TM_NONE,
        TM_NAND1,
        TM_NAND2,
        TM_NAND3,
        TM_NAND4,
        TM_ALLZ
    } stme_test_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_COUNT,
        ST_DONE
    } stme_phase_t;

    typedef struct packed {
        logic noReboot;
        logic safeMode;
    } stme_straps_t;

    typedef struct packed {
        logic            [1:0] pwrSync;
        logic            [1:0] rtcSync;
        logic            [1:0] pciSync;
        logic            [1:0] spkrSync;
        logic            [1:0] codecSync;
        logic                  pwrPrev;
        stme_phase_t           phase;
        logic            [4:0] lowCount;
        stme_straps_t          straps;
        stme_test_mode_t       testMode;
        logic                  testValid;
    } stme_state_t;

endpackage

`default_nettype wire

// ===== stme_strap_entry.sv
`timescale 1ns/1ps
`default_nettype none
`include "stme_consts.svh"

module stme_strap_entry (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // Board pins, asynchronous to clk
    input  wire logic                       powerGoodInput,
    input  wire logic                       pciBusReset_n,
    input  wire logic                       batteryWellReset_n,
    input  wire logic                       speakerStrapPin,
    input  wire logic                       codecSerialOutPin,
    // Strap results
    output logic                            strapsLatched,
    output logic                            watchdogRebootInhibit,
    output logic                            safeSpeedSelect,
    output logic                      [7:0] strapStatus,
    // Test mode results
    output stme_pkg::stme_test_mode_t       testMode,
    output logic                            testModeValid,
    output logic                            allOutputsHighZ
);

    stme_pkg::stme_state_t state;
    stme_pkg::stme_state_t next_state;
    logic                  powerRise;
    logic                  rtcLow;

    // Rise seen on the second sync stage only; the first stage feeds nothing else
    assign powerRise = state.pwrSync[1] & ~state.pwrPrev;
    assign rtcLow    = ~state.rtcSync[1];

    always_comb begin
        next_state = state;
        next_state.pwrSync   = {state.pwrSync[0], powerGoodInput};
        next_state.rtcSync   = {state.rtcSync[0], batteryWellReset_n};
        next_state.pciSync   = {state.pciSync[0], pciBusReset_n};
        next_state.spkrSync  = {state.spkrSync[0], speakerStrapPin};
        next_state.codecSync = {state.codecSync[0], codecSerialOutPin};
        next_state.pwrPrev   = state.pwrSync[1];
        if (powerRise) begin
            // Straps sampled once, pins then free for normal use
            next_state.straps.noReboot = ~state.spkrSync[1];
            next_state.straps.safeMode = state.codecSync[1];
            next_state.testMode  = stme_pkg::TM_NONE;
            next_state.testValid = 1'b0;
            next_state.lowCount  = 5'h00;
            next_state.phase     = stme_pkg::ST_ARMED;
        end else if (!state.pwrSync[1]) begin
            // Test entry only while power-good is high; straps still held
            next_state.phase    = stme_pkg::ST_IDLE;
            next_state.lowCount = 5'h00;
        end else begin
            unique case (state.phase)
                stme_pkg::ST_IDLE: begin
                    next_state.phase = stme_pkg::ST_IDLE;
                end
                stme_pkg::ST_ARMED: begin
                    // Bus reset must be released before a low pulse counts
                    if (rtcLow && state.pciSync[1]) begin
                        next_state.phase    = stme_pkg::ST_COUNT;
                        next_state.lowCount = 5'h01;
                    end
                end
                stme_pkg::ST_COUNT: begin
                    if (rtcLow) begin
                        // Saturate so long pulses still decode as over 24
                        if (state.lowCount != `STME_COUNT_MAX) begin
                            next_state.lowCount = state.lowCount + 5'h01;
                        end
                    end else begin
                        next_state.phase     = stme_pkg::ST_DONE;
                        next_state.testValid = 1'b1;
                        if (state.lowCount >= `STME_TEST_MIN && state.lowCount < `STME_TEST_ALLZ) begin
                            // Counts 4..7 map to chains 1..4
                            next_state.testMode = stme_pkg::stme_test_mode_t'(3'(state.lowCount - 5'h03));
                        end else if (state.lowCount == `STME_TEST_ALLZ) begin
                            next_state.testMode = stme_pkg::TM_ALLZ;
                        end else begin
                            // Reserved counts also decode to none, a safe fallback
                            next_state.testMode = stme_pkg::TM_NONE;
                        end
                    end
                end
                stme_pkg::ST_DONE: begin
                    // One decode per power-good rise
                    next_state.phase = stme_pkg::ST_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // Sync stages reset to the pins' idle levels, so no false edge follows reset
            state <= '{pwrSync:   2'h0,
                       rtcSync:   2'h3,
                       pciSync:   2'h0,
                       spkrSync:  {2{`STME_SPEAKER_STRAP_PIN_RESET}},
                       codecSync: {2{`STME_CODEC_RESET}},
                       pwrPrev:   1'h0,
                       phase:     stme_pkg::ST_IDLE,
                       lowCount:  5'h00,
                       straps:    '{noReboot: 1'h0, safeMode: 1'h0},
                       testMode:  stme_pkg::TM_NONE,
                       testValid: 1'h0};
            strapsLatched         <= 1'b0;
            watchdogRebootInhibit <= 1'b0;
            safeSpeedSelect       <= 1'b0;
            strapStatus           <= 8'h00;
            testMode              <= stme_pkg::TM_NONE;
            testModeValid         <= 1'b0;
            allOutputsHighZ       <= 1'b0;
        end else begin
            state <= next_state;
            if (powerRise) begin
                strapsLatched <= 1'b1;
            end
            watchdogRebootInhibit <= next_state.straps.noReboot;
            safeSpeedSelect       <= next_state.straps.safeMode;
            strapStatus <= 8'h00;
            strapStatus[`STME_NO_REBOOT_BIT] <= next_state.straps.noReboot;
            strapStatus[`STME_SAFE_MODE_BIT] <= next_state.straps.safeMode;
            testMode        <= next_state.testMode;
            testModeValid   <= next_state.testValid;
            allOutputsHighZ <= (next_state.testMode == stme_pkg::TM_ALLZ);
        end
    end

    // Outputs register with the decision, so checks look one edge after it

    strap_latch_a : assert property (@(posedge clk) disable iff (!rst_b)
        powerRise |=> watchdogRebootInhibit == !$past(state.spkrSync[1])
                      && safeSpeedSelect == $past(state.codecSync[1]))
        else $error("strap latch wrong");

    latch_flag_a : assert property (@(posedge clk) disable iff (!rst_b)
        powerRise |=> strapsLatched)
        else $error("latched flag not set");

    status_bits_a : assert property (@(posedge clk) disable iff (!rst_b)
        strapStatus[2:1] == {safeSpeedSelect, watchdogRebootInhibit} && strapStatus[7:3] == 5'h00
        && strapStatus[0] == 1'b0)
        else $error("status bits mismatch");

    noreboot_status_a : assert property (@(posedge clk) disable iff (!rst_b)
        powerRise |=> strapStatus[`STME_NO_REBOOT_BIT] == !$past(state.spkrSync[1]))
        else $error("reboot status bit wrong");

    safe_status_a : assert property (@(posedge clk) disable iff (!rst_b)
        powerRise |=> strapStatus[`STME_SAFE_MODE_BIT] == $past(state.codecSync[1]))
        else $error("safe status bit wrong");

    count_gate_a : assert property (@(posedge clk) disable iff (!rst_b)
        !state.pwrSync[1] |=> state.lowCount == 5'h00)
        else $error("counting without power-good");

    count_step_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state.phase == stme_pkg::ST_COUNT && rtcLow && state.pwrSync[1] && !powerRise
         && state.lowCount != `STME_COUNT_MAX)
        |=> state.lowCount == $past(state.lowCount) + 5'h01)
        else $error("low clock not counted");

    arm_gate_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state.phase == stme_pkg::ST_ARMED && !state.pciSync[1] && state.pwrSync[1] && !powerRise)
        |=> state.phase == stme_pkg::ST_ARMED)
        else $error("count began under bus reset");

    nand_decode_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state.phase == stme_pkg::ST_COUNT && !rtcLow && state.pwrSync[1] && !powerRise
         && state.lowCount == 5'h05)
        |=> testMode == stme_pkg::TM_NAND2)
        else $error("count 5 not chain 2");

    // One check per chain count
    for (genvar g = 0; g < 4; g++) begin : gen_chain
        chain_decode_a : assert property (@(posedge clk) disable iff (!rst_b)
            (state.phase == stme_pkg::ST_COUNT && !rtcLow && state.pwrSync[1] && !powerRise
             && state.lowCount == 5'(`STME_TEST_MIN + g))
            |=> testMode == stme_pkg::stme_test_mode_t'(3'(g + 1)) && testModeValid)
            else $error("chain count decoded wrong");
    end

    low_none_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state.phase == stme_pkg::ST_COUNT && !rtcLow && state.pwrSync[1] && !powerRise
         && state.lowCount < `STME_TEST_MIN)
        |=> testMode == stme_pkg::TM_NONE && testModeValid)
        else $error("short pulse gave a mode");

    allz_decode_a : assert property (@(posedge clk) disable iff (!rst_b)
        allOutputsHighZ |-> testMode == stme_pkg::TM_ALLZ && testModeValid)
        else $error("high-Z without mode");

    allz_count_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state.phase == stme_pkg::ST_COUNT && !rtcLow && state.pwrSync[1] && !powerRise
         && state.lowCount == `STME_TEST_ALLZ)
        |=> testMode == stme_pkg::TM_ALLZ && allOutputsHighZ)
        else $error("count 8 not all high-Z");

    reserved_none_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state.phase == stme_pkg::ST_COUNT && !rtcLow && state.pwrSync[1] && !powerRise
         && (state.lowCount == `STME_TEST_NONE9 || state.lowCount > `STME_TEST_RSVD_MAX))
        |=> testMode == stme_pkg::TM_NONE)
        else $error("count should give none");

    hold_result_a : assert property (@(posedge clk) disable iff (!rst_b)
        (state.phase == stme_pkg::ST_DONE && !powerRise) |=> $stable(testMode))
        else $error("mode changed");

    hold_straps_a : assert property (@(posedge clk) disable iff (!rst_b)
        !powerRise |=> $stable(watchdogRebootInhibit) && $stable(safeSpeedSelect))
        else $error("strap changed");

    rise_clear_a : assert property (@(posedge clk) disable iff (!rst_b)
        powerRise |=> testMode == stme_pkg::TM_NONE && !testModeValid && !allOutputsHighZ)
        else $error("mode not cleared on rise");

endmodule

`default_nettype wire

// ===== stme_board_model.sv
`timescale 1ns/1ps
`default_nettype none

module stme_board_model (
    // Clock
    input  wire logic clk,
    // Board pins
    output logic      powerGoodInput,
    output logic      pciBusReset_n,
    output logic      batteryWellReset_n,
    output logic      speakerStrapPin,
    output logic      codecSerialOutPin
);
    initial begin
        powerGoodInput = 1'h0;
        pciBusReset_n = 1'h0;
        batteryWellReset_n = 1'h1;
        speakerStrapPin = 1'h1;
        codecSerialOutPin = 1'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic powerUp(input logic spk, input logic codec);
        tick(1);
        powerGoodInput = 1'h0;
        pciBusReset_n = 1'h0;
        tick(3);
        speakerStrapPin = spk;
        codecSerialOutPin = codec;
        tick(4);
        powerGoodInput = 1'h1;
        tick(5);
        // Pins back in functional use, so their levels must no longer matter
        speakerStrapPin = ~spk;
        codecSerialOutPin = ~codec;
        pciBusReset_n = 1'h1;
        tick(3);
    endtask

    // Callers never ask for 10 to 24 low clocks
    task automatic testPulse(input int n);
        batteryWellReset_n = 1'h0;
        tick(n);
        batteryWellReset_n = 1'h1;
        tick(6);
    endtask

    task automatic powerDown();
        powerGoodInput = 1'h0;
        tick(4);
    endtask
endmodule

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                      clk;
    logic                      rst_b;
    logic                      powerGoodInput;
    logic                      pciBusReset_n;
    logic                      batteryWellReset_n;
    logic                      speakerStrapPin;
    logic                      codecSerialOutPin;
    logic                      strapsLatched;
    logic                      watchdogRebootInhibit;
    logic                      safeSpeedSelect;
    logic                [7:0] strapStatus;
    stme_pkg::stme_test_mode_t testMode;
    logic                      testModeValid;
    logic                      allOutputsHighZ;
    int                        nMismatch = 0;
    int                        testsRun = 0;
    int                        cycles = 0;

    stme_strap_entry stme_strap_entry_inst (.clk(clk), .rst_b(rst_b), .powerGoodInput(powerGoodInput),
        .pciBusReset_n(pciBusReset_n), .batteryWellReset_n(batteryWellReset_n),
        .speakerStrapPin(speakerStrapPin), .codecSerialOutPin(codecSerialOutPin),
        .strapsLatched(strapsLatched), .watchdogRebootInhibit(watchdogRebootInhibit),
        .safeSpeedSelect(safeSpeedSelect), .strapStatus(strapStatus), .testMode(testMode),
        .testModeValid(testModeValid), .allOutputsHighZ(allOutputsHighZ));

    stme_board_model stme_board_model_inst (.clk(clk), .powerGoodInput(powerGoodInput),
        .pciBusReset_n(pciBusReset_n), .batteryWellReset_n(batteryWellReset_n),
        .speakerStrapPin(speakerStrapPin), .codecSerialOutPin(codecSerialOutPin));

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input string what, input logic [7:0] expv, input logic [7:0] got);
        testsRun++;
        if (got !== expv) begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", what, expv, got);
        end
    endtask

    task automatic tally_and_finish();
        if (nMismatch == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            nMismatch++;
            tally_and_finish();
        end
    end

    task automatic straps_case();
        check("unlatched", 8'h00, 8'(strapsLatched));
        for (int i = 0; i < 4; i++) begin
            stme_board_model_inst.powerUp(i[0], i[1]);
            check("latched", 8'h01, 8'(strapsLatched));
            check("inhibit", 8'(!i[0]), 8'(watchdogRebootInhibit));
            check("safe", 8'(i[1]), 8'(safeSpeedSelect));
            check("status", {5'h00, 1'(i[1]), 1'(!i[0]), 1'h0}, strapStatus);
        end
    endtask

    task automatic decode_case();
        int                        counts[8] = '{3, 4, 5, 6, 7, 9, 25, 8};
        stme_pkg::stme_test_mode_t modes[8] = '{stme_pkg::TM_NONE, stme_pkg::TM_NAND1, stme_pkg::TM_NAND2,
            stme_pkg::TM_NAND3, stme_pkg::TM_NAND4, stme_pkg::TM_NONE, stme_pkg::TM_NONE, stme_pkg::TM_ALLZ};
        for (int i = 0; i < 8; i++) begin
            stme_board_model_inst.powerUp(1'h1, 1'h0);
            check("cleared", 8'(stme_pkg::TM_NONE), 8'(testMode));
            stme_board_model_inst.testPulse(counts[i]);
            check("mode", 8'(modes[i]), 8'(testMode));
            check("valid", 8'h01, 8'(testModeValid));
            check("highZ", 8'(modes[i] == stme_pkg::TM_ALLZ), 8'(allOutputsHighZ));
        end
    endtask

    task automatic hold_case();
        stme_board_model_inst.testPulse(5);
        check("second pulse", 8'(stme_pkg::TM_ALLZ), 8'(testMode));
        stme_board_model_inst.powerDown();
        stme_board_model_inst.testPulse(4);
        check("pulse unpowered", 8'(stme_pkg::TM_ALLZ), 8'(testMode));
        check("highZ held", 8'h01, 8'(allOutputsHighZ));
    endtask

    initial begin
        rst_b = 1'h0;
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'h1;
        repeat (3) @(posedge clk);
        straps_case();
        decode_case();
        hold_case();
        tally_and_finish();
    end
endmodule

`default_nettype wire
